// >>> test/cil_issue_interlock_checker.sv
`timescale 1ns/1ps
module cil_issue_interlock_checker
(
  input wire logic           clk,
  input wire logic           rst_b,
  input wire logic           instr_valid,
  input cil_pkg::cil_instr_t instr,
  input wire logic           instr_ready,
  input wire logic           issue_fire,
  input wire logic [4:0]     issue_lat_r,
  input wire logic           hazard_stall,
  input wire logic           handler_enter
);
  import cil_pkg::*;

  // --------------------------------
  // issue handshake
  // --------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_b);

  fire_rule_a : assert property (issue_fire == (instr_valid && instr_ready))
    else $error("fire differs from valid and ready");
  stall_meaning_a : assert property (hazard_stall |-> instr_valid && !instr_ready && !issue_fire)
    else $error("stall while issuing");
  lat_hold_a : assert property (!issue_fire |=> $stable(issue_lat_r))
    else $error("latency changed without issue");

  // --------------------------------
  // per class timing
  // --------------------------------
  dp_single_a : assert property (issue_fire && instr.op == CIL_OP_DP && !instr.shift_reg && !instr.writes_pc
    |=> issue_lat_r == CIL_LAT_1) else $error("plain data op latency");
  dp_shift_a : assert property (issue_fire && instr.op == CIL_OP_DP && instr.shift_reg && !instr.writes_pc
    |=> issue_lat_r == CIL_LAT_2 && !instr_ready) else $error("shifted data op latency");
  swap_busy_a : assert property (issue_fire && instr.op == CIL_OP_SWAP
    |=> (issue_lat_r == CIL_LAT_5 && !instr_ready) [*4]) else $error("swap issued early");
  mode_write_a : assert property (issue_fire && instr.op == CIL_OP_STAT_WR && instr.mode_change
    |=> (issue_lat_r == CIL_LAT_6 && !instr_ready) [*5]) else $error("mode write issued early");
  swi_handler_a : assert property (issue_fire && instr.op == CIL_OP_SWI
    |=> !handler_enter [*4] ##1 handler_enter) else $error("handler entry not at five");
  handler_cause_a : assert property (handler_enter |-> $past(issue_fire && instr.op == CIL_OP_SWI, 5))
    else $error("handler entry without interrupt");
  load_use_a : assert property (issue_fire && instr.op == CIL_OP_LOAD && instr.dst0_v && !instr.base_v
    ##1 instr_valid && instr.src0_v && instr.src0 == $past(instr.dst0) |-> !issue_fire)
    else $error("load data consumed early");
endmodule

bind cil_issue_interlock cil_issue_interlock_checker chk_u (.clk(clk), .rst_b(rst_b), .instr_valid(instr_valid),
  .instr(instr), .instr_ready(instr_ready), .issue_fire(issue_fire), .issue_lat_r(issue_lat_r),
  .hazard_stall(hazard_stall), .handler_enter(handler_enter));

// >>> test/tb.sv
`timescale 1ns/1ps
`define CHK(got, exp, msg) \
  begin \
    cmp_count++; \
    if ((got) !== (exp)) begin \
      bad_count++; \
      $display("unexpected at %0t: %s got %0d exp %0d", $time, msg, got, exp); \
    end \
  end

module tb;
  import cil_pkg::*;

  typedef struct packed {
    logic [4:0] lat;
    logic [7:0] gap;
  } cil_exp_t;

  logic       clk;
  logic       rst_b;
  logic       instr_valid;
  cil_instr_t instr;
  logic       instr_ready;
  logic       issue_fire;
  logic [4:0] issue_lat_r;
  logic       hazard_stall;
  logic       handler_enter;
  int         bad_count = 0;
  int         cmp_count = 0;
  int         cyc = 0;
  int         last_cyc = 0;
  int         swi_cyc = -100;
  logic       pend = 1'b0;
  logic [4:0] pend_lat;
  cil_exp_t   exp_q[$];
  cil_exp_t   e;
  cil_instr_t x;
  cil_instr_t y;
  logic [4:0] prev;

  cil_issue_interlock dut_u (.clk(clk), .rst_b(rst_b), .instr_valid(instr_valid), .instr(instr),
    .instr_ready(instr_ready), .issue_fire(issue_fire), .issue_lat_r(issue_lat_r),
    .hazard_stall(hazard_stall), .handler_enter(handler_enter));

  always #12.5 clk = ~clk;
  always @(posedge clk) cyc <= cyc + 1;

  // --------------------------------
  // monitor: oldest note per issue
  // --------------------------------
  always @(negedge clk) begin
    if (pend) begin
      `CHK(issue_lat_r, pend_lat, "issue latency")
      pend = 1'b0;
    end
    if (handler_enter === 1'b1) begin
      `CHK(8'(cyc - swi_cyc), 8'h05, "handler delay")
    end
    if (rst_b && issue_fire === 1'b1) begin
      if (exp_q.size() == 0) begin
        `CHK(1'b1, 1'b0, "issue without request")
      end else begin
        e = exp_q.pop_front();
        if (e.gap != 8'h00)
          `CHK(8'(cyc - last_cyc), e.gap, "issue gap")
        pend = 1'b1;
        pend_lat = e.lat;
      end
      last_cyc = cyc;
      if (instr.op == CIL_OP_SWI)
        swi_cyc = cyc;
    end
  end

  // --------------------------------
  // driver
  // --------------------------------
  // nregs rides on the low operand bits; no class reads both
  function automatic cil_instr_t mk(cil_op_t op, logic [7:0] fl, logic [31:0] mo);
    cil_instr_t r;
    r = '0;
    r.op = op;
    r.mult_operand = mo;
    r.nregs = mo[4:0];
    {r.first_r12, r.mode_change, r.mispredict, r.taken, r.writes_pc, r.shift_reg, r.signed_mul, r.flags_set} = fl;
    return r;
  endfunction

  task automatic summarize();
    $display("compares %0d mismatches %0d", cmp_count, bad_count);
    if (bad_count == 0 && cmp_count > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask

  task automatic issue(input cil_instr_t i, input logic [4:0] lat, input logic [7:0] gap);
    int n;
    exp_q.push_back({lat, gap});
    instr = i;
    instr_valid = 1'b1;
    n = 0;
    do begin
      @(negedge clk);
      n++;
    end while (issue_fire !== 1'b1 && n < 40);
    if (issue_fire !== 1'b1) begin
      bad_count++;
      $display("unexpected at %0t: request never taken", $time);
      summarize();
    end
    @(posedge clk);
    #2;
  endtask

  task automatic idle(input int n);
    instr_valid = 1'b0;
    repeat (n) @(posedge clk);
    #2;
  endtask

  // a class, then a plain data op whose spacing shows the issue latency
  task automatic t(input cil_op_t op, input logic [7:0] fl, input logic [31:0] mo, input int lat);
    issue(mk(op, fl, mo), 5'(lat), 8'h00);
    issue(mk(CIL_OP_DP, 8'h00, 32'h0), 5'h01, 8'(lat));
    idle(6);
  endtask

  initial begin
    clk = 1'b0;
    rst_b = 1'b0;
    instr_valid = 1'b0;
    instr = '0;
    repeat (8) @(posedge clk);
    #2;
    rst_b = 1'b1;
    void'($urandom(64516));

    t(CIL_OP_DP, 8'h00, 32'h0, 1);
    t(CIL_OP_DP, 8'h04, 32'h0, 2);
    t(CIL_OP_DP, 8'h08, 32'h0, 1);
    t(CIL_OP_DP, 8'h18, 32'h0, 5);
    t(CIL_OP_DP, 8'h1C, 32'h0, 6);
    t(CIL_OP_BR_IMM, 8'h10, 32'h0, 1);
    t(CIL_OP_BR_IMM, 8'h30, 32'h0, 5);
    t(CIL_OP_BR_IMM, 8'h20, 32'h0, 5);
    t(CIL_OP_BR_REG, 8'h00, 32'h0, 1);
    t(CIL_OP_BR_REG, 8'h10, 32'h0, 5);
    t(CIL_OP_BLX_IMM, 8'h10, 32'h0, 5);
    t(CIL_OP_LDR_PC, 8'h08, 32'h0, 2);
    t(CIL_OP_LDR_PC, 8'h18, 32'h0, 8);
    t(CIL_OP_LOAD_MUL, 8'h08, 32'h05, 8);
    t(CIL_OP_LOAD_MUL, 8'h18, 32'h05, 12);
    t(CIL_OP_MUL32, 8'h00, 32'h40000000, 1);
    t(CIL_OP_MUL32, 8'h01, 32'hFFFF8000, 2);
    t(CIL_OP_MUL32, 8'h01, 32'h07000000, 3);
    t(CIL_OP_MUL32, 8'h01, 32'h40000000, 4);
    t(CIL_OP_MAC64, 8'h02, 32'h40000000, 2);
    t(CIL_OP_MAC64, 8'h03, 32'hFFFFFFFF, 3);
    t(CIL_OP_MAC64, 8'h01, 32'hFFFFFFFF, 5);
    t(CIL_OP_MUL64, 8'h02, 32'h40000000, 1);
    t(CIL_OP_MUL64, 8'h03, 32'h00000000, 3);
    t(CIL_OP_ACC_MUL, 8'h00, 32'h40000000, 1);
    t(CIL_OP_ACC_HW, 8'h00, 32'h0, 1);
    t(CIL_OP_ACC_PH, 8'h00, 32'h0, 1);
    t(CIL_OP_ACC_WR, 8'h00, 32'h0, 2);
    t(CIL_OP_ACC_RD, 8'h00, 32'h0, 1);
    t(CIL_OP_SAT, 8'h00, 32'h0, 1);
    t(CIL_OP_STAT_RD, 8'h00, 32'h0, 1);
    t(CIL_OP_STAT_WR, 8'h00, 32'h0, 2);
    t(CIL_OP_STAT_WR, 8'h40, 32'h0, 6);
    t(CIL_OP_LOAD, 8'h00, 32'h0, 1);
    t(CIL_OP_STORE, 8'h00, 32'h0, 1);
    t(CIL_OP_LOAD_DW, 8'h80, 32'h0, 2);
    t(CIL_OP_STORE_DW, 8'h00, 32'h0, 2);
    t(CIL_OP_LOAD_MUL, 8'h00, 32'h10, 18);
    t(CIL_OP_STORE_MUL, 8'h00, 32'h01, 3);
    t(CIL_OP_SWAP, 8'h00, 32'h0, 5);
    t(CIL_OP_SYS_RD, 8'h00, 32'h0, 4);
    t(CIL_OP_SYS_WR, 8'h00, 32'h0, 2);
    t(CIL_OP_DBG_RD, 8'h00, 32'h0, 7);
    t(CIL_OP_DBG_WR, 8'h00, 32'h0, 7);
    t(CIL_OP_CP_LOAD, 8'h00, 32'h0, 10);
    t(CIL_OP_CP_STORE, 8'h00, 32'h0, 7);
    t(CIL_OP_SWI, 8'h00, 32'h0, 6);
    t(CIL_OP_CLZ, 8'h00, 32'h0, 1);
    $display("test class latencies done");

    // --------------------------------
    // result hazards and multiplier spacing
    // --------------------------------
    x = mk(CIL_OP_LOAD, 8'h00, 32'h0);
    x.dst0 = 4'h3;
    x.dst0_v = 1'b1;
    issue(x, 5'h01, 8'h00);
    y = mk(CIL_OP_DP, 8'h00, 32'h0);
    y.src0 = 4'h3;
    y.src0_v = 1'b1;
    issue(y, 5'h01, 8'h03);
    x = mk(CIL_OP_DP, 8'h00, 32'h0);
    x.dst0 = 4'h4;
    x.dst0_v = 1'b1;
    issue(x, 5'h01, 8'h01);
    y = mk(CIL_OP_DP, 8'h00, 32'h0);
    {y.src2, y.src2_v, y.src2_late} = {4'h4, 2'b11};
    issue(y, 5'h01, 8'h02);
    idle(6);
    x = mk(CIL_OP_MUL32, 8'h00, 32'h40000000);
    {x.dst0, x.dst0_v} = {4'h6, 1'b1};
    issue(x, 5'h01, 8'h00);
    y = mk(CIL_OP_DP, 8'h00, 32'h0);
    {y.src0, y.src0_v} = {4'h6, 1'b1};
    issue(y, 5'h01, 8'h04);
    idle(6);
    issue(x, 5'h01, 8'h00);
    issue(mk(CIL_OP_MUL32, 8'h00, 32'h0), 5'h01, 8'h03);
    idle(6);
    x = mk(CIL_OP_LOAD_DW, 8'h00, 32'h0);
    {x.dst0, x.dst0_v, x.dst1, x.dst1_v} = {4'h1, 1'b1, 4'h2, 1'b1};
    issue(x, 5'h01, 8'h00);
    y = mk(CIL_OP_DP, 8'h00, 32'h0);
    {y.src1, y.src1_v} = {4'h2, 1'b1};
    issue(y, 5'h01, 8'h04);
    idle(6);
    x = mk(CIL_OP_MAC64, 8'h02, 32'h40000000);
    {x.dst1, x.dst1_v} = {4'h7, 1'b1};
    issue(x, 5'h02, 8'h00);
    y = mk(CIL_OP_DP, 8'h00, 32'h0);
    {y.src1, y.src1_v} = {4'h7, 1'b1};
    issue(y, 5'h01, 8'h05);
    idle(6);
    $display("test hazards done");

    // --------------------------------
    // random back-to-back data ops
    // --------------------------------
    prev = 5'h00;
    for (int k = 0; k < 24; k++) begin
      x = mk(CIL_OP_DP, 8'($urandom_range(0, 1)) << 2, $urandom);
      {x.dst0, x.dst0_v} = {4'($urandom), 1'b1};
      issue(x, x.shift_reg ? 5'h02 : 5'h01, {3'h0, prev});
      prev = x.shift_reg ? 5'h02 : 5'h01;
    end
    idle(8);
    $display("test random data ops done");
    summarize();
  end
endmodule

// >>> verilog/cil_issue_interlock.sv
`timescale 1ns/1ps
// Summary of operation
// - addressing modes add no cycles
// - immediate branches 1 predicted, 5 mispredicted
// - register branches 1/5; immediate exchange 5
// - taken pc-writing data op adds 4
// - pc loads 2/8; multiple 3+n/10+excess
// - data ops 1, or 2 when register-shifted
// - shift/doubling consumers wait one extra
// - word multiply early termination timing
// - long accumulate timing, unsigned zeros only
// - long multiply issues 1 without flags
// - accumulator multiply 1/2/3 by operand
// - accumulator write 2; read 2/3
// - saturating ops issue 1, result 2
// - status read 1/2; write 2 or 6
// - single loads data 3, base 1
// - doubleword load 3/4, base 2
// - multiple transfers 2+n, pc-writing loads 3+n or 10+excess
// - swap issue and result 5
// - system coprocessor read 4, write 2
// - debug coprocessor 7, coprocessor load 10
// - interrupt instruction reaches handler after 6
// - leading-zero count issues 1, result 1
module cil_issue_interlock
  import cil_pkg::*;
(
  input  wire logic               clk,
  input  wire logic               rst_b,
  input  wire logic               instr_valid,
  input  cil_pkg::cil_instr_t     instr,
  output logic                    instr_ready,
  output logic                    issue_fire,
  output logic [4:0]              issue_lat_r,
  output logic                    hazard_stall,
  output logic                    handler_enter
);
  import cil_pkg::*;

  // ------------------------------------------------------------
  // state of the issue sequencer
  // ------------------------------------------------------------
  typedef enum logic [2:0] {
    CIL_ST_IDLE = 3'b001,
    CIL_ST_BUSY = 3'b010,
    CIL_ST_TRAP = 3'b100
  } cil_state_t;

  cil_state_t   state_r;
  cil_state_t   state_nxt;
  cil_timing_t  timing;
  logic [4:0]   busy_r;
  logic [4:0]   mul_busy_r;
  logic [4:0]   reg_cnt_r [CIL_NREG];
  logic         reg_late_r [CIL_NREG];
  logic         src_block;
  logic         mul_block;
  logic         slot_free;

  cil_latency_decode u_decode (
    .instr  (instr),
    .timing (timing)
  );

  // ------------------------------------------------------------
  // hazard checks
  // ------------------------------------------------------------
  // a late-forwarded producer needs one more cycle for shift or doubling use;
  // the late flag outlives the count by exactly one cycle, which is that extra cycle
  function automatic logic src_wait(input logic [3:0] r, input logic v, input logic late,
                                    input logic [4:0] cnt, input logic lflag);
    return v && ((cnt != CIL_CNT_W0) || (late && lflag));
  endfunction

  always_comb begin
    src_block = src_wait(instr.src0, instr.src0_v, instr.src0_late,
                         reg_cnt_r[instr.src0], reg_late_r[instr.src0])
             || src_wait(instr.src1, instr.src1_v, 1'b0,
                         reg_cnt_r[instr.src1], reg_late_r[instr.src1])
             || src_wait(instr.src2, instr.src2_v, instr.src2_late,
                         reg_cnt_r[instr.src2], reg_late_r[instr.src2]);
  end

  assign mul_block    = timing.is_mul && (mul_busy_r != CIL_CNT_W0);
  assign slot_free    = (state_r == CIL_ST_IDLE);
  assign instr_ready  = slot_free && !src_block && !mul_block;
  assign issue_fire   = instr_valid && instr_ready;
  assign hazard_stall = instr_valid && slot_free && (src_block || mul_block);

  // ------------------------------------------------------------
  // issue sequencer
  // ------------------------------------------------------------
  always_comb begin
    state_nxt = state_r;
    case (state_r)
      CIL_ST_IDLE: begin
        if (issue_fire && instr.op == CIL_OP_SWI) begin
          state_nxt = CIL_ST_TRAP;
        end else if (issue_fire && timing.issue > CIL_LAT_1) begin
          state_nxt = CIL_ST_BUSY;
        end
      end
      CIL_ST_BUSY: begin
        if (busy_r == CIL_LAT_1) begin
          state_nxt = CIL_ST_IDLE;
        end
      end
      CIL_ST_TRAP: begin
        if (busy_r == CIL_LAT_1) begin
          state_nxt = CIL_ST_IDLE;
        end
      end
      default: state_nxt = CIL_ST_IDLE;
    endcase
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      state_r <= CIL_ST_IDLE;
    end else begin
      state_r <= state_nxt;
    end
  end

  // remaining cycles until the next issue slot opens
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      busy_r <= CIL_CNT_W0;
    end else if (issue_fire) begin
      busy_r <= timing.issue - CIL_LAT_1;
    end else if (busy_r != CIL_CNT_W0) begin
      busy_r <= busy_r - CIL_LAT_1;
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      issue_lat_r <= CIL_CNT_W0;
    end else if (issue_fire) begin
      issue_lat_r <= timing.issue;
    end
  end

  // handler's first instruction may issue in the cycle after this pulse
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      handler_enter <= 1'b0;
    end else begin
      handler_enter <= (state_r == CIL_ST_TRAP) && (busy_r == CIL_LAT_2);
    end
  end

  // multiplier resource: next multiply waits out the throughput figure
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      mul_busy_r <= CIL_CNT_W0;
    end else if (issue_fire && timing.is_mul) begin
      mul_busy_r <= timing.thru - CIL_LAT_1;
    end else if (mul_busy_r != CIL_CNT_W0) begin
      mul_busy_r <= mul_busy_r - CIL_LAT_1;
    end
  end

  // ------------------------------------------------------------
  // per-register result scoreboard
  // ------------------------------------------------------------
  // counts hold cycles left before a consumer may issue; a new producer overwrites
  generate
    for (genvar g = 0; g < CIL_NREG; g++) begin : g_sb
      logic hit0;
      logic hit1;
      logic hitb;
      assign hit0 = issue_fire && instr.dst0_v && (instr.dst0 == 4'(g));
      assign hit1 = issue_fire && instr.dst1_v && (instr.dst1 == 4'(g));
      assign hitb = issue_fire && instr.base_v && (instr.base == 4'(g));
      always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
          reg_cnt_r[g]  <= CIL_CNT_W0;
          reg_late_r[g] <= 1'b0;
        end else if (hit1) begin
          reg_cnt_r[g]  <= timing.res1 - CIL_LAT_1;
          reg_late_r[g] <= timing.late_fwd;
        end else if (hit0) begin
          reg_cnt_r[g]  <= timing.res0 - CIL_LAT_1;
          reg_late_r[g] <= timing.late_fwd;
        end else if (hitb) begin
          reg_cnt_r[g]  <= timing.res_base - CIL_LAT_1;
          reg_late_r[g] <= 1'b0;
        end else if (reg_cnt_r[g] != CIL_CNT_W0) begin
          reg_cnt_r[g]  <= reg_cnt_r[g] - CIL_LAT_1;
        end else begin
          reg_late_r[g] <= 1'b0;
        end
      end
    end
  endgenerate

endmodule

// >>> verilog/cil_latency_decode.sv
`timescale 1ns/1ps
module cil_latency_decode
  import cil_pkg::*;
(
  input  cil_pkg::cil_instr_t  instr,
  output cil_pkg::cil_timing_t timing
);
  import cil_pkg::*;

  logic [16:0] w_hi;
  logic [4:0]  n_hi;
  logic        w_uni;
  logic        n_uni;
  logic        w_zero;
  logic        n_zero;
  logic [1:0]  et_cls;
  logic [1:0]  acc_cls;
  logic [4:0]  ldm_extra;
  logic [4:0]  dp_lat;

  assign w_hi   = instr.mult_operand[CIL_ET_HI:CIL_ET_W_LO];
  assign n_hi   = instr.mult_operand[CIL_ET_HI:CIL_ET_N_LO];
  assign w_zero = (w_hi == 17'h00000);
  assign n_zero = (n_hi == 5'h00);
  assign w_uni  = w_zero | (w_hi == 17'h1FFFF);
  assign n_uni  = n_zero | (n_hi == 5'h1F);

  // early termination class 0/1/2; unsigned long forms only terminate on zeros
  always_comb begin
    if (instr.op == CIL_OP_MUL32 || instr.signed_mul) begin
      et_cls = w_uni ? 2'h0 : (n_uni ? 2'h1 : 2'h2);
    end else begin
      et_cls = w_zero ? 2'h0 : (n_zero ? 2'h1 : 2'h2);
    end
  end

  always_comb begin
    if (&instr.mult_operand[CIL_ET_HI:CIL_ET_AW_LO] || ~|instr.mult_operand[CIL_ET_HI:CIL_ET_AW_LO]) begin
      acc_cls = 2'h0;
    end else if (&instr.mult_operand[CIL_ET_HI:CIL_ET_AN_LO] || ~|instr.mult_operand[CIL_ET_HI:CIL_ET_AN_LO]) begin
      acc_cls = 2'h1;
    end else begin
      acc_cls = 2'h2;
    end
  end

  assign ldm_extra = (instr.nregs > CIL_LAT_3) ? (instr.nregs - CIL_LAT_3) : CIL_CNT_W0;
  assign dp_lat    = instr.shift_reg ? CIL_LAT_2 : CIL_LAT_1;

  always_comb begin
    timing          = '0;
    timing.issue    = CIL_LAT_1;
    timing.res0     = CIL_LAT_1;
    timing.res1     = CIL_LAT_1;
    timing.res_base = CIL_LAT_1;
    timing.thru     = CIL_LAT_1;
    case (instr.op)
      CIL_OP_DP: begin
        timing.issue    = (instr.writes_pc && instr.taken) ? dp_lat + CIL_BR_PENALTY : dp_lat;
        timing.res0     = dp_lat;
        timing.late_fwd = 1'b1;
      end
      CIL_OP_BR_IMM: timing.issue = instr.mispredict ? CIL_LAT_5 : CIL_LAT_1;
      CIL_OP_BR_REG: timing.issue = instr.taken ? CIL_LAT_5 : CIL_LAT_1;
      CIL_OP_BLX_IMM: timing.issue = CIL_LAT_5;
      CIL_OP_LDR_PC: timing.issue = instr.taken ? CIL_LAT_8 : CIL_LAT_2;
      CIL_OP_MUL32: begin
        timing.is_mul   = 1'b1;
        timing.late_fwd = 1'b1;
        timing.res0     = CIL_LAT_2 + {3'h0, et_cls};
        if (instr.flags_set) begin
          timing.issue = CIL_LAT_2 + {3'h0, et_cls};
          timing.thru  = CIL_LAT_2 + {3'h0, et_cls};
        end else begin
          timing.issue = CIL_LAT_1;
          timing.thru  = CIL_LAT_1 + {3'h0, et_cls};
        end
      end
      CIL_OP_MAC64, CIL_OP_MUL64: begin
        timing.is_mul   = 1'b1;
        timing.late_fwd = 1'b1;
        if (instr.flags_set) begin
          timing.issue = CIL_LAT_3 + {3'h0, et_cls};
          timing.res0  = CIL_LAT_3 + {3'h0, et_cls};
          timing.res1  = CIL_LAT_3 + {3'h0, et_cls};
          timing.thru  = CIL_LAT_3 + {3'h0, et_cls};
        end else begin
          timing.issue = (instr.op == CIL_OP_MUL64) ? CIL_LAT_1 : CIL_LAT_2;
          timing.res0  = CIL_LAT_2 + {3'h0, et_cls};
          timing.res1  = CIL_LAT_3 + {3'h0, et_cls};
          timing.thru  = CIL_LAT_2 + {3'h0, et_cls};
        end
      end
      CIL_OP_ACC_MUL: begin
        timing.is_mul = 1'b1;
        timing.res0   = CIL_LAT_1 + {3'h0, acc_cls};
        timing.thru   = CIL_LAT_1 + {3'h0, acc_cls};
      end
      CIL_OP_ACC_HW: timing.is_mul = 1'b1;
      CIL_OP_ACC_PH: begin
        timing.is_mul = 1'b1;
        timing.res0   = CIL_LAT_2;
        timing.thru   = CIL_LAT_2;
      end
      CIL_OP_ACC_WR: begin
        timing.is_mul = 1'b1;
        timing.issue  = CIL_LAT_2;
        timing.res0   = CIL_LAT_2;
        timing.thru   = CIL_LAT_2;
      end
      CIL_OP_ACC_RD: begin
        timing.is_mul   = 1'b1;
        timing.late_fwd = 1'b1;
        timing.res0     = CIL_LAT_2;
        timing.res1     = CIL_LAT_3;
        timing.thru     = CIL_LAT_2;
      end
      CIL_OP_SAT: timing.res0 = CIL_LAT_2;
      CIL_OP_STAT_RD: timing.res0 = CIL_LAT_2;
      CIL_OP_STAT_WR: timing.issue = instr.mode_change ? CIL_LAT_6 : CIL_LAT_2;
      CIL_OP_LOAD: timing.res0 = CIL_LAT_3;
      CIL_OP_STORE: timing.issue = CIL_LAT_1;
      CIL_OP_LOAD_DW: begin
        timing.issue    = instr.first_r12 ? CIL_LAT_2 : CIL_LAT_1;
        timing.res0     = CIL_LAT_3;
        timing.res1     = CIL_LAT_4;
        timing.res_base = CIL_LAT_2;
      end
      CIL_OP_STORE_DW: timing.issue = CIL_LAT_2;
      CIL_OP_LOAD_MUL: begin
        if (instr.writes_pc) begin
          timing.issue = instr.taken ? CIL_LAT_10 + ldm_extra : CIL_LDMPC_NT + instr.nregs;
        end else begin
          timing.issue = CIL_LDM_BASE + instr.nregs;
        end
        timing.res0 = CIL_LAT_3;
      end
      CIL_OP_STORE_MUL: timing.issue = CIL_LDM_BASE + instr.nregs;
      CIL_OP_SWAP: begin
        timing.issue = CIL_LAT_5;
        timing.res0  = CIL_LAT_5;
      end
      CIL_OP_SYS_RD: begin
        timing.issue = CIL_LAT_4;
        timing.res0  = CIL_LAT_4;
      end
      CIL_OP_SYS_WR: timing.issue = CIL_LAT_2;
      CIL_OP_DBG_RD: begin
        timing.issue = CIL_LAT_7;
        timing.res0  = CIL_LAT_7;
      end
      CIL_OP_DBG_WR, CIL_OP_CP_STORE: timing.issue = CIL_LAT_7;
      CIL_OP_CP_LOAD: timing.issue = CIL_LAT_10;
      CIL_OP_SWI: timing.issue = CIL_LAT_6;
      CIL_OP_CLZ: timing.res0 = CIL_LAT_1;
      default: timing.issue = CIL_LAT_1;
    endcase
  end

endmodule

// >>> verilog/cil_pkg.sv
package cil_pkg;

  // instruction classes presented at the issue stage
  typedef enum logic [4:0] {
    CIL_OP_DP         = 5'h00,
    CIL_OP_BR_IMM     = 5'h01,
    CIL_OP_BR_REG     = 5'h02,
    CIL_OP_BLX_IMM    = 5'h03,
    CIL_OP_LDR_PC     = 5'h04,
    CIL_OP_MUL32      = 5'h05,
    CIL_OP_MAC64      = 5'h06,
    CIL_OP_MUL64      = 5'h07,
    CIL_OP_ACC_MUL    = 5'h08,
    CIL_OP_ACC_HW     = 5'h09,
    CIL_OP_ACC_PH     = 5'h0A,
    CIL_OP_ACC_WR     = 5'h0B,
    CIL_OP_ACC_RD     = 5'h0C,
    CIL_OP_SAT        = 5'h0D,
    CIL_OP_STAT_RD    = 5'h0E,
    CIL_OP_STAT_WR    = 5'h0F,
    CIL_OP_LOAD       = 5'h10,
    CIL_OP_STORE      = 5'h11,
    CIL_OP_LOAD_DW    = 5'h12,
    CIL_OP_STORE_DW   = 5'h13,
    CIL_OP_LOAD_MUL   = 5'h14,
    CIL_OP_STORE_MUL  = 5'h15,
    CIL_OP_SWAP       = 5'h16,
    CIL_OP_SYS_RD     = 5'h17,
    CIL_OP_SYS_WR     = 5'h18,
    CIL_OP_DBG_RD     = 5'h19,
    CIL_OP_DBG_WR     = 5'h1A,
    CIL_OP_CP_LOAD    = 5'h1B,
    CIL_OP_CP_STORE   = 5'h1C,
    CIL_OP_SWI        = 5'h1D,
    CIL_OP_CLZ        = 5'h1E
  } cil_op_t;

  // one instruction offered to the issue stage
  typedef struct packed {
    cil_op_t     op;
    logic [31:0] mult_operand;  // multiplier operand value, for early termination
    logic        flags_set;     // status-setting form
    logic        signed_mul;    // signed long multiply
    logic        shift_reg;     // operand shifted by register or rotate_right_extend
    logic        writes_pc;     // destination or list holds the program counter
    logic        taken;         // resolved direction
    logic        mispredict;    // branch target buffer guessed wrong
    logic        mode_change;   // status write touches mode bits
    logic        first_r12;     // doubleword load first destination is register 12
    logic [4:0]  nregs;         // register count for multiple transfers
    logic [3:0]  dst0;          // first destination register
    logic [3:0]  dst1;          // second destination (high word / odd register)
    logic        dst0_v;
    logic        dst1_v;
    logic [3:0]  base;          // base register written back
    logic        base_v;
    logic [3:0]  src0;          // first operand (saturating first operand slot)
    logic [3:0]  src1;
    logic [3:0]  src2;          // operand used as immediate shift source
    logic        src0_v;
    logic        src1_v;
    logic        src2_v;
    logic        src0_late;     // src0 is first operand of a doubling saturate
    logic        src2_late;     // src2 feeds an immediate shift
  } cil_instr_t;

  // timing answer for the instruction being issued
  typedef struct packed {
    logic [4:0] issue;
    logic [4:0] res0;
    logic [4:0] res1;
    logic [4:0] res_base;
    logic [4:0] thru;
    logic       is_mul;
    logic       late_fwd;  // producer class whose result comes later to shift/doubling use
  } cil_timing_t;

  localparam int          CIL_NREG        = 16;
  localparam logic [4:0]  CIL_CNT_W0      = 5'h00;
  localparam logic [4:0]  CIL_LAT_1       = 5'h01;
  localparam logic [4:0]  CIL_LAT_2       = 5'h02;
  localparam logic [4:0]  CIL_LAT_3       = 5'h03;
  localparam logic [4:0]  CIL_LAT_4       = 5'h04;
  localparam logic [4:0]  CIL_LAT_5       = 5'h05;
  localparam logic [4:0]  CIL_LAT_6       = 5'h06;
  localparam logic [4:0]  CIL_LAT_7       = 5'h07;
  localparam logic [4:0]  CIL_LAT_8       = 5'h08;
  localparam logic [4:0]  CIL_LAT_10      = 5'h0A;
  localparam logic [4:0]  CIL_BR_PENALTY  = 5'h04;
  localparam logic [4:0]  CIL_LDM_PC_BASE = 5'h07;
  localparam logic [4:0]  CIL_LDM_BASE    = 5'h02;
  localparam logic [4:0]  CIL_LDMPC_NT    = 5'h03;
  localparam logic [3:0]  CIL_REG_R12     = 4'hC;
  localparam logic [3:0]  CIL_ACC_SLOT    = 4'h0;
  localparam int          CIL_ET_HI       = 31;
  localparam int          CIL_ET_W_LO    = 15;
  localparam int          CIL_ET_N_LO    = 27;
  localparam int          CIL_ET_AW_LO   = 16;
  localparam int          CIL_ET_AN_LO   = 28;

endpackage
